//--- core/hdsp_pkg.sv
package hdsp_pkg;
  // ----------------------------------------------------------------
  // widths and strap fields
  // ----------------------------------------------------------------
  localparam int HDSP_DATA_W = 32;
  localparam int HDSP_PAR_W = 4;
  localparam int HDSP_BYTE_W = 8;
  localparam int HDSP_TEST_BIT = 11;
  localparam int HDSP_ADDR_W = 16;
  localparam logic HDSP_ORDER_HIGH = 1'h1;
  localparam int HDSP_CLK_PERIOD_NS = 10;

  typedef enum logic [2:0] {
    HDSP_ST_RESET = 3'h1,
    HDSP_ST_NORMAL = 3'h2,
    HDSP_ST_CLKTEST = 3'h4
  } hdsp_mode_e;

  // even parity per byte lane: xor of a byte
  function automatic logic [HDSP_PAR_W-1:0] hdsp_even_par(
      input logic [HDSP_DATA_W-1:0] d);
    logic [HDSP_PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < HDSP_PAR_W; i++) begin
      p[i] = ^d[i*HDSP_BYTE_W +: HDSP_BYTE_W];
    end
    return p;
  endfunction : hdsp_even_par
endpackage : hdsp_pkg

//--- core/hdsp_slice.sv
// Summary of operation
// - high slice captures test strap at reset release
// - strap low: normal mode, no clock output
// - strap high on the high slice: half-rate copy of host clock driven on order pin
// - order strap chooses high or low lanes
// - each parity line covers one data byte
// - host drives parity on writes, slice on reads
// - even parity, same timing as data
`timescale 1ns/1ps
`default_nettype none
module hdsp_slice
  import hdsp_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // straps and order pin (two-way in clock test)
  input wire logic order_strap_pin_in,
  output logic order_strap_pin_out,
  output logic order_strap_pin_oe_out,
  input wire logic [HDSP_ADDR_W-1:0] host_addr_in,
  // host data and parity pins
  input wire logic [HDSP_DATA_W-1:0] host_data_in,
  input wire logic [HDSP_PAR_W-1:0] host_byte_parity_in,
  output logic [HDSP_DATA_W-1:0] host_data_out,
  output logic [HDSP_PAR_W-1:0] host_byte_parity_out,
  output logic host_data_oe_out,
  // controller strobes
  input wire logic host_write_in,
  input wire logic host_read_in,
  // host write stream toward internal paths
  output logic wr_valid_out,
  input wire logic wr_ready_in,
  output logic [HDSP_DATA_W-1:0] wr_data_out,
  output logic wr_par_err_out,
  // internal read data toward host
  input wire logic [HDSP_DATA_W-1:0] rd_data_in,
  output logic rd_ready_out,
  // status
  output logic high_slice_out,
  output logic clk_test_out,
  output logic overflow_out
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ord_s_q, ord_s_d;
  logic [1:0] tst_s_q, tst_s_d;
  logic [1:0] wr_s_q, wr_s_d, rd_s_q, rd_s_d;
  logic [HDSP_DATA_W-1:0] hd_s1_q, hd_s1_d, hd_s2_q, hd_s2_d;
  logic [HDSP_PAR_W-1:0] hp_s1_q, hp_s1_d, hp_s2_q, hp_s2_d;

  always_comb begin
    ord_s_d = {ord_s_q[0], order_strap_pin_in};
    tst_s_d = {tst_s_q[0], host_addr_in[HDSP_TEST_BIT]};
    wr_s_d = {wr_s_q[0], host_write_in};
    rd_s_d = {rd_s_q[0], host_read_in};
    hd_s1_d = host_data_in;
    hd_s2_d = hd_s1_q;
    hp_s1_d = host_byte_parity_in;
    hp_s2_d = hp_s1_q;
  end

  // strap synchronisers run through reset, so the straps have settled by
  // the time reset is released; clearing them would hide the straps
  always_ff @(posedge clock_in) begin
    ord_s_q <= ord_s_d;
    tst_s_q <= tst_s_d;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      wr_s_q <= '0;
      rd_s_q <= '0;
      hd_s1_q <= '0;
      hd_s2_q <= '0;
      hp_s1_q <= '0;
      hp_s2_q <= '0;
    end else begin
      wr_s_q <= wr_s_d;
      rd_s_q <= rd_s_d;
      hd_s1_q <= hd_s1_d;
      hd_s2_q <= hd_s2_d;
      hp_s1_q <= hp_s1_d;
      hp_s2_q <= hp_s2_d;
    end
  end

  // ----------------------------------------------------------------
  // strap capture and mode
  // ----------------------------------------------------------------
  // straps are taken on the first clock after reset release; the
  // reset branch loads constants only.
  hdsp_mode_e mode_q, mode_d;
  logic high_q, high_d;

  always_comb begin
    mode_d = mode_q;
    high_d = high_q;
    unique case (mode_q)
      HDSP_ST_RESET: begin
        high_d = (ord_s_q[1] == HDSP_ORDER_HIGH);
        if (ord_s_q[1] == HDSP_ORDER_HIGH && tst_s_q[1]) begin
          mode_d = HDSP_ST_CLKTEST;
        end else begin
          mode_d = HDSP_ST_NORMAL;
        end
      end
      HDSP_ST_NORMAL: mode_d = HDSP_ST_NORMAL;
      HDSP_ST_CLKTEST: mode_d = HDSP_ST_CLKTEST;
      default: mode_d = HDSP_ST_RESET;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      mode_q <= HDSP_ST_RESET;
      high_q <= 1'h0;
    end else begin
      mode_q <= mode_d;
      high_q <= high_d;
    end
  end

  assign high_slice_out = high_q;
  assign clk_test_out = (mode_q == HDSP_ST_CLKTEST);

  // ----------------------------------------------------------------
  // clock test output on the order pin
  // ----------------------------------------------------------------
  // limitation: the pin carries a registered half-rate copy of the
  // host clock, since a clock is not passed through plain logic.
  logic clk_div_q, clk_div_d;
  always_comb clk_div_d = clk_test_out ? ~clk_div_q : 1'h0;
  always_ff @(posedge clock_in) begin
    if (!rstn_in) clk_div_q <= 1'h0;
    else clk_div_q <= clk_div_d;
  end
  assign order_strap_pin_out = clk_div_q;
  assign order_strap_pin_oe_out = clk_test_out;

  // ----------------------------------------------------------------
  // host write path: two-entry buffer with parity check
  // ----------------------------------------------------------------
  logic [HDSP_DATA_W-1:0] buf_q [2], buf_d [2];
  logic [1:0] perr_q, perr_d;
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d;
  logic push, pop;

  always_comb begin
    buf_d = buf_q;
    perr_d = perr_q;
    wp_d = wp_q;
    rp_d = rp_q;
    ovf_d = ovf_q;
    push = wr_s_q[1] && (mode_q != HDSP_ST_RESET);
    pop = wr_valid_out && wr_ready_in;
    if (push && cnt_q == 2'h2 && !pop) begin
      ovf_d = 1'h1;
      push = 1'h0;
    end
    if (push) begin
      buf_d[wp_q] = hd_s2_q;
      perr_d[wp_q] = (hdsp_even_par(hd_s2_q) != hp_s2_q);
      wp_d = ~wp_q;
    end
    if (pop) rp_d = ~rp_q;
    cnt_d = cnt_q + {1'h0, push} - {1'h0, pop};
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      perr_q <= '0;
      wp_q <= 1'h0;
      rp_q <= 1'h0;
      cnt_q <= '0;
      ovf_q <= 1'h0;
    end else begin
      buf_q <= buf_d;
      perr_q <= perr_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  assign wr_valid_out = (cnt_q != 2'h0);
  assign wr_data_out = buf_q[rp_q];
  assign wr_par_err_out = wr_valid_out && perr_q[rp_q];
  assign overflow_out = ovf_q;

  // ----------------------------------------------------------------
  // host read path: data and parity launched together
  // ----------------------------------------------------------------
  logic [HDSP_DATA_W-1:0] hdo_q, hdo_d;
  logic [HDSP_PAR_W-1:0] hpo_q, hpo_d;
  logic oe_q, oe_d;

  always_comb begin
    oe_d = rd_s_q[1] && (mode_q != HDSP_ST_RESET);
    hdo_d = oe_d ? rd_data_in : hdo_q;
    hpo_d = oe_d ? hdsp_even_par(rd_data_in) : hpo_q;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      hdo_q <= '0;
      hpo_q <= '0;
      oe_q <= 1'h0;
    end else begin
      hdo_q <= hdo_d;
      hpo_q <= hpo_d;
      oe_q <= oe_d;
    end
  end

  assign host_data_out = hdo_q;
  assign host_byte_parity_out = hpo_q;
  assign host_data_oe_out = oe_q;
  assign rd_ready_out = oe_d;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_low_never_test: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !high_q |-> !clk_test_out) else $error("low slice in clock test");
  a_mode_sticks: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_q != HDSP_ST_RESET |=> $stable(mode_q)) else $error("mode moved");
  a_strap_to_mode: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (rstn_in && mode_q == HDSP_ST_RESET && ord_s_q[1] && tst_s_q[1])
      |=> clk_test_out) else $error("clock test missed");
  a_normal_no_oe: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mode_q == HDSP_ST_NORMAL |-> !order_strap_pin_oe_out)
    else $error("order pin driven");
  a_test_oe: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_test_out |=> order_strap_pin_oe_out && $changed(order_strap_pin_out))
    else $error("test clock absent");
  a_order_lanes: assert property (@(posedge clock_in) disable iff (!rstn_in)
    rstn_in && mode_q == HDSP_ST_RESET |=> high_q == $past(ord_s_q[1]))
    else $error("lane select wrong");
  a_rd_parity: assert property (@(posedge clock_in) disable iff (!rstn_in)
    host_data_oe_out |-> host_byte_parity_out == hdsp_even_par(host_data_out))
    else $error("read parity wrong");
  a_rd_timing: assert property (@(posedge clock_in) disable iff (!rstn_in)
    rd_s_q[1] && mode_q != HDSP_ST_RESET |=> host_data_oe_out
      && host_data_out == $past(rd_data_in)) else $error("read late");
  a_wr_no_oe: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !rd_s_q[1] |=> !host_data_oe_out) else $error("drove on write");
endmodule : hdsp_slice
`default_nettype wire

//--- verification/hdsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// host bus model, write side
// ------------------------------
module hdsp_host_model
  import hdsp_pkg::*;
(
  // clock
  input wire logic clock_in,
  // bench command
  input wire logic send_in,
  input wire logic [HDSP_DATA_W-1:0] word_in,
  input wire logic [HDSP_PAR_W-1:0] flip_in,
  // host pins
  output logic [HDSP_DATA_W-1:0] data_out,
  output logic [HDSP_PAR_W-1:0] par_out
);
  logic [HDSP_DATA_W-1:0] held_q = '0;
  logic [HDSP_PAR_W-1:0] hpar_q = '0;
  logic [HDSP_PAR_W-1:0] even;
  assign even = {^word_in[31:24], ^word_in[23:16], ^word_in[15:8],
                 ^word_in[7:0]};
  // released lines toggle so a stale sample cannot pass
  assign data_out = send_in ? word_in : ~held_q;
  assign par_out = send_in ? even ^ flip_in : ~hpar_q;
  always_ff @(posedge clock_in) begin
    held_q <= data_out;
    hpar_q <= par_out;
  end
endmodule : hdsp_host_model
`default_nettype wire

//--- verification/host_data_slice_parity_bench.sv
`timescale 1ns/1ps
`default_nettype none
module host_data_slice_parity_bench;
  import hdsp_pkg::*;
  logic clock_in = 1'h0, rstn_in = 1'h0, ord = 1'h0, send = 1'h0;
  logic host_write_in = 1'h0, host_read_in = 1'h0, wr_ready_in = 1'h0;
  logic stall = 1'h0;
  logic rdy;
  logic [1:0] rdl = 2'h0;
  logic [3:0] wact = 4'h0;
  logic [31:0] rd_p = 32'h0;
  logic [15:0] host_addr_in = 16'h0;
  logic [31:0] word = 32'h0, rd_v = 32'h0, rd_data_in = 32'h0, mdat;
  logic [31:0] hdo, wdo, hdi;
  logic [3:0] flip = 4'h0, mpar, hpo, hpi;
  logic pin_o, pin_oe, pin_w, doe, wv, werr, hs, ct, ovf, prev;
  logic [32:0] wq[$];
  logic [35:0] rq[$];
  int seed = 32'h863B, rnd, mismatches = 0, tests_run = 0, cyc = 0;
  always #5 clock_in = ~clock_in;
  assign pin_w = pin_oe ? pin_o : ord;
  assign hdi = doe ? hdo : mdat;
  assign hpi = doe ? hpo : mpar;
  hdsp_host_model host (.clock_in(clock_in), .send_in(send),
    .word_in(word), .flip_in(flip), .data_out(mdat), .par_out(mpar));
  hdsp_slice dut (.clock_in(clock_in), .rstn_in(rstn_in),
    .order_strap_pin_in(pin_w), .order_strap_pin_out(pin_o),
    .order_strap_pin_oe_out(pin_oe), .host_addr_in(host_addr_in),
    .host_data_in(hdi), .host_byte_parity_in(hpi),
    .host_data_out(hdo), .host_byte_parity_out(hpo),
    .host_data_oe_out(doe), .host_write_in(host_write_in),
    .host_read_in(host_read_in), .wr_valid_out(wv),
    .wr_ready_in(wr_ready_in), .wr_data_out(wdo), .wr_par_err_out(werr),
    .rd_data_in(rd_data_in), .rd_ready_out(rdy), .high_slice_out(hs),
    .clk_test_out(ct), .overflow_out(ovf));
  function automatic logic [3:0] evp(input logic [31:0] d);
    evp = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction : evp
  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(input string n, input logic [35:0] e,
      input logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // -------------------
  // monitor and driving
  // -------------------
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
    rnd = $random(seed);
    // the host cannot be held off, so unless stalled the sink takes every word
    // still in the synchronisers and idles at random otherwise
    wr_ready_in <= !stall && (rnd[0] || |wact);
    wact <= {wact[2:0], host_write_in};
    // read data must stand when the synchronised read is taken
    rd_p <= rd_v;
    rd_data_in <= rd_p;
    rdl <= {rdl[0], host_read_in};
    if (rstn_in) chk_bit("read ready", rdl[1], rdy);
    if (wv && wr_ready_in)
      chk_word("write word", wq.pop_front(), {3'h0, werr, wdo});
    if (doe) chk_word("read word", rq.pop_front(), {hpo, hdo});
  end
  task automatic do_reset(input logic o, input logic t);
    while (wq.size() != 0) @(posedge clock_in);
    chk_bit("drained", 1'h1, wq.size() == 0 && rq.size() == 0);
    rnd = $random(seed);
    rstn_in <= 1'h0;
    ord <= o;
    host_addr_in <= {rnd[15:12], t, rnd[10:0]};
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'h1;
    repeat (3) @(posedge clock_in);
    #1;
    chk_bit("high slice", o, hs);
    chk_bit("clock test", o & t, ct);
    chk_bit("pin enable", o & t, pin_oe);
    prev = pin_o;
    @(posedge clock_in);
    #1;
    if (o & t) chk_bit("test clock", !prev, pin_o);
    @(posedge clock_in);
  endtask : do_reset
  task automatic wr_burst(input int n, input logic [3:0] f, input int keep);
    for (int i = 0; i < n; i++) begin
      rnd = $random(seed);
      send <= 1'h1;
      host_write_in <= 1'h1;
      word <= rnd;
      flip <= f;
      if (i < keep) wq.push_back({f != 4'h0, rnd});
      @(posedge clock_in);
    end
    send <= 1'h0;
    host_write_in <= 1'h0;
    repeat (12) @(posedge clock_in);
  endtask : wr_burst
  initial begin
    do_reset(1'h1, 1'h0);
    wr_burst(8, 4'h0, 8);
    for (int i = 0; i < 4; i++) wr_burst(1, 4'h1 << i, 1);
    for (int i = 0; i < 6; i++) begin
      rnd = $random(seed);
      rd_v <= rnd;
      host_read_in <= 1'h1;
      rq.push_back({evp(rnd), rnd});
      @(posedge clock_in);
    end
    host_read_in <= 1'h0;
    repeat (10) @(posedge clock_in);
    stall <= 1'h1;
    wr_burst(3, 4'h0, 2);
    chk_bit("overflow", 1'h1, ovf);
    stall <= 1'h0;
    repeat (10) @(posedge clock_in);
    do_reset(1'h0, 1'h1);
    wr_burst(2, 4'h0, 2);
    do_reset(1'h1, 1'h1);
    give_verdict();
  end
endmodule : host_data_slice_parity_bench
`default_nettype wire
